// *** logic/scss_top.sv ***
// system clock source selection, prescaler and digital pll model
`timescale 1ns/10ps
`default_nettype none
`include "scss_defs.svh"

// Contract
// - select 11 drives clock from external pin
// - select 10 with bypass uses prescaled oscillator
// - prescale factor is field plus one
// - prescaler reaches divide factor 1024
// - factor one passes oscillator with duty
// - select 10 without bypass enables pll
// - pll multiplies by N over P times K2
// - pll reference is crystal or internal source
// - pll adjusts frequency gradually, one step per window; a band change clamps it at once
// - system clock is vco divided by K2
// - band select sets vco frequency range
// - select 00 runs from wakeup clock
// - bypass with factor one passes the oscillator, one cycle later than direct drive passes the pin
module scss_top #(
    parameter int K1_W  = `SCSS_K1_W,
    parameter int P_W   = `SCSS_P_W,
    parameter int K2_W  = `SCSS_K2_W,
    parameter int INC_W = `SCSS_INC_W
) (
    input  wire logic                      clk_sys,              // system logic clock
    input  wire logic                      arst_n,               // async reset, active low
    input  wire logic                      external_clock_pin,   // direct drive clock level
    input  wire logic                      crystal_input_pin,    // crystal oscillator level
    input  wire logic                      internal_osc_clk,     // on-chip clock source level
    input  wire logic                      wakeup_clk,           // low-frequency wakeup level
    input  wire scss_pkg::scss_sys_cfg_type sys_cfg,             // source and prescaler config
    input  wire scss_pkg::scss_pll_cfg_type pll_cfg,             // pll config
    output var  logic                      sys_clk,              // generated system clock level
    output var  scss_pkg::scss_src_type    active_source,        // source now in use
    output var  logic                      pll_enable,           // pll running
    output var  logic                      pll_locked,           // pll frequency locked
    output var  logic [INC_W-1:0]          vco_increment         // current vco control word
);
    import scss_pkg::*;

    // oscillator path selection shared by prescaler and pll
    logic osc_level;
    logic k1_level;
    logic ref_level;
    logic k2_level;

    assign osc_level = sys_cfg.osc_from_internal ? internal_osc_clk
                                                 : crystal_input_pin;

    // prescaler: factor is field plus one, 10-bit field gives 1..1024
    scss_edge_div #(
        .W         (K1_W)
    ) u_k1_div (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .in_level  (osc_level),
        .factor_m1 (sys_cfg.prescaler_divider_field),
        .out_level (k1_level)
    );

    // pll input divider P on the reference
    scss_edge_div #(
        .W         (P_W)
    ) u_p_div (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .in_level  (osc_level),
        .factor_m1 (pll_cfg.pll_input_divider_field),
        .out_level (ref_level)
    );

    // decode of selected mode
    logic mode_pll;
    logic mode_presc;
    always_comb
    begin
        mode_pll   = (sys_cfg.clock_source_select == `SCSS_SEL_OSC)
                     && !sys_cfg.vco_bypass;
        mode_presc = (sys_cfg.clock_source_select == `SCSS_SEL_OSC)
                     && sys_cfg.vco_bypass;
    end

    // band limits of the controlled vco
    logic [INC_W-1:0] inc_min;
    logic [INC_W-1:0] inc_max;
    always_comb
    begin
        if (pll_cfg.vco_band_select == `SCSS_BAND_LOW)
        begin
            inc_min = `SCSS_BAND0_MIN;
            inc_max = `SCSS_BAND0_MAX;
        end
        else
        begin
            inc_min = `SCSS_BAND1_MIN;
            inc_max = `SCSS_BAND1_MAX;
        end
    end

    // numerically controlled vco: carry of the accumulator toggles its level
    logic [INC_W-1:0] nco_acc;
    logic             vco_level;
    logic [INC_W-1:0] next_nco_acc;
    logic             next_vco_level;
    logic [INC_W:0]   nco_sum;

    always_comb
    begin
        nco_sum        = {1'b0, nco_acc} + {1'b0, vco_increment};
        next_nco_acc   = nco_acc;
        next_vco_level = vco_level;
        if (pll_enable)
        begin
            next_nco_acc = nco_sum[INC_W-1:0];
            if (nco_sum[INC_W])
            begin
                next_vco_level = ~vco_level;
            end
        end
        else
        begin
            next_nco_acc   = '0;
            next_vco_level = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            nco_acc   <= '0;
            vco_level <= 1'b0;
        end
        else
        begin
            nco_acc   <= next_nco_acc;
            vco_level <= next_vco_level;
        end
    end

    // output divider K2 after the vco
    scss_edge_div #(
        .W         (K2_W)
    ) u_k2_div (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .in_level  (vco_level),
        .factor_m1 (pll_cfg.pll_output_divider_field),
        .out_level (k2_level)
    );

    // frequency loop: count vco periods per divided reference period
    scss_pll_state_type pll_state;
    scss_pll_state_type next_pll_state;
    logic               ref_prev;
    logic               vco_prev;
    logic [7:0]         fb_cnt;
    logic [3:0]         lock_cnt;
    logic               next_ref_prev;
    logic               next_vco_prev;
    logic [7:0]         next_fb_cnt;
    logic [3:0]         next_lock_cnt;
    logic [INC_W-1:0]   next_vco_increment;
    logic               next_pll_enable;
    logic               next_pll_locked;
    logic [7:0]         n_target;
    logic [INC_W:0]     inc_up;
    logic [INC_W-1:0]   inc_dn;
    logic               ref_rise;
    logic               vco_rise;

    always_comb
    begin
        n_target = {1'b0, pll_cfg.pll_feedback_multiplier_field} + 8'h01;
        ref_rise = ref_level && !ref_prev;
        vco_rise = vco_level && !vco_prev;
        inc_up   = {1'b0, vco_increment} + {1'b0, `SCSS_INC_STEP};
        inc_dn   = (vco_increment > inc_min + `SCSS_INC_STEP)
                   ? vco_increment - `SCSS_INC_STEP : inc_min;
        next_ref_prev      = ref_level;
        next_vco_prev      = vco_level;
        next_pll_state     = pll_state;
        next_fb_cnt        = fb_cnt;
        next_lock_cnt      = lock_cnt;
        next_vco_increment = vco_increment;
        case (pll_state)
            SCSS_PLL_OFF:
            begin
                next_fb_cnt        = 8'h00;
                next_lock_cnt      = 4'h0;
                next_vco_increment = inc_min;
                if (mode_pll)
                begin
                    next_pll_state = SCSS_PLL_ACQUIRE;
                end
            end
            default:
            begin
                if (vco_rise && fb_cnt != 8'hFF)
                begin
                    next_fb_cnt = fb_cnt + 8'h01;
                end
                if (ref_rise)
                begin
                    next_fb_cnt = 8'h00;
                    // one step per window keeps the frequency moving smoothly
                    if (fb_cnt < n_target)
                    begin
                        next_vco_increment = (inc_up > {1'b0, inc_max})
                                             ? inc_max : inc_up[INC_W-1:0];
                        next_lock_cnt      = 4'h0;
                        next_pll_state     = SCSS_PLL_ACQUIRE;
                    end
                    else if (fb_cnt > n_target)
                    begin
                        next_vco_increment = inc_dn;
                        next_lock_cnt      = 4'h0;
                        next_pll_state     = SCSS_PLL_ACQUIRE;
                    end
                    else if (lock_cnt == `SCSS_LOCK_WINDOWS)
                    begin
                        next_pll_state = SCSS_PLL_LOCKED;
                    end
                    else
                    begin
                        next_lock_cnt = lock_cnt + 4'h1;
                    end
                end
                // band change clamps the control word into the new range
                if (next_vco_increment > inc_max)
                begin
                    next_vco_increment = inc_max;
                end
                else if (next_vco_increment < inc_min)
                begin
                    next_vco_increment = inc_min;
                end
                if (!mode_pll)
                begin
                    next_pll_state = SCSS_PLL_OFF;
                end
            end
        endcase
        next_pll_enable = (next_pll_state != SCSS_PLL_OFF);
        next_pll_locked = (next_pll_state == SCSS_PLL_LOCKED);
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pll_state     <= SCSS_PLL_OFF;
            ref_prev      <= 1'b0;
            vco_prev      <= 1'b0;
            fb_cnt        <= 8'h00;
            lock_cnt      <= 4'h0;
            vco_increment <= `SCSS_BAND0_MIN;
            pll_enable    <= 1'b0;
            pll_locked    <= 1'b0;
        end
        else
        begin
            pll_state     <= next_pll_state;
            ref_prev      <= next_ref_prev;
            vco_prev      <= next_vco_prev;
            fb_cnt        <= next_fb_cnt;
            lock_cnt      <= next_lock_cnt;
            vco_increment <= next_vco_increment;
            pll_enable    <= next_pll_enable;
            pll_locked    <= next_pll_locked;
        end
    end

    // system clock source multiplexer
    logic         next_sys_clk;
    scss_src_type next_active_source;
    always_comb
    begin
        next_sys_clk       = wakeup_clk;
        next_active_source = SCSS_SRC_WAKEUP;
        case (sys_cfg.clock_source_select)
            `SCSS_SEL_DIRECT:
            begin
                next_sys_clk       = external_clock_pin;
                next_active_source = SCSS_SRC_DIRECT;
            end
            `SCSS_SEL_OSC:
            begin
                if (mode_presc)
                begin
                    next_sys_clk       = k1_level;
                    next_active_source = SCSS_SRC_PRESCALER;
                end
                else
                begin
                    next_sys_clk       = k2_level;
                    next_active_source = SCSS_SRC_PLL;
                end
            end
            `SCSS_SEL_WAKEUP:
            begin
                next_sys_clk       = wakeup_clk;
                next_active_source = SCSS_SRC_WAKEUP;
            end
            default:
            begin
                // reserved code stays on the wakeup clock
                next_sys_clk       = wakeup_clk;
                next_active_source = SCSS_SRC_WAKEUP;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sys_clk       <= 1'b0;
            active_source <= SCSS_SRC_WAKEUP;
        end
        else
        begin
            sys_clk       <= next_sys_clk;
            active_source <= next_active_source;
        end
    end
endmodule // scss_top
`default_nettype wire

// *** logic/scss_defs.svh ***
// constants for the system clock source select block
`ifndef SCSS_DEFS_SVH
`define SCSS_DEFS_SVH

// source selection codes
`define SCSS_SEL_WAKEUP    2'h0
`define SCSS_SEL_RESERVED  2'h1
`define SCSS_SEL_OSC       2'h2
`define SCSS_SEL_DIRECT    2'h3

// vco band codes
`define SCSS_BAND_LOW      2'h0
`define SCSS_BAND_HIGH     2'h1

// field widths
`define SCSS_K1_W          10
`define SCSS_P_W           4
`define SCSS_N_W           7
`define SCSS_K2_W          7
`define SCSS_INC_W         16

// vco band limits as nco increments, scaled 50:110 and 100:160 MHz
`define SCSS_BAND0_MIN     16'h0500
`define SCSS_BAND0_MAX     16'h0B00
`define SCSS_BAND1_MIN     16'h0A00
`define SCSS_BAND1_MAX     16'h1000

// loop adjustment step and lock qualification
`define SCSS_INC_STEP      16'h0004
`define SCSS_LOCK_WINDOWS  4'h4

`endif

// *** logic/scss_pkg.sv ***
// types for the system clock source select block
`include "scss_defs.svh"
package scss_pkg;

    // configuration of source selection and prescaler
    typedef struct packed {
        logic [1:0]             clock_source_select;
        logic                   vco_bypass;
        logic                   osc_from_internal;
        logic [`SCSS_K1_W-1:0]  prescaler_divider_field;
    } scss_sys_cfg_type;

    // configuration of the phase locked loop
    typedef struct packed {
        logic [`SCSS_P_W-1:0]   pll_input_divider_field;
        logic [`SCSS_N_W-1:0]   pll_feedback_multiplier_field;
        logic [`SCSS_K2_W-1:0]  pll_output_divider_field;
        logic [1:0]             vco_band_select;
    } scss_pll_cfg_type;

    // source currently driving the system clock
    typedef enum logic [2:0] {
        SCSS_SRC_WAKEUP,
        SCSS_SRC_PRESCALER,
        SCSS_SRC_PLL,
        SCSS_SRC_DIRECT
    } scss_src_type;

    // phase locked loop states
    typedef enum logic [1:0] {
        SCSS_PLL_OFF,
        SCSS_PLL_ACQUIRE,
        SCSS_PLL_LOCKED
    } scss_pll_state_type;

endpackage

// *** logic/scss_edge_div.sv ***
// clock level divider by factor field plus one, counting both edges
`timescale 1ns/10ps
`default_nettype none
module scss_edge_div #(
    parameter int W = 10
) (
    input  wire logic         clk_sys,     // system clock
    input  wire logic         arst_n,      // async reset, active low
    input  wire logic         in_level,    // sampled input clock level
    input  wire logic [W-1:0] factor_m1,   // divide factor minus one
    output var  logic         out_level    // divided clock level
);
    logic         in_prev;
    logic [W-1:0] edge_cnt;
    logic         next_in_prev;
    logic [W-1:0] next_edge_cnt;
    logic         next_out_level;

    // toggle every factor input edges: output period is factor input periods
    always_comb
    begin
        next_in_prev   = in_level;
        next_edge_cnt  = edge_cnt;
        next_out_level = out_level;
        if (factor_m1 == '0)
        begin
            next_edge_cnt  = '0;
            next_out_level = in_level;   // pass through keeps duty cycle
        end
        else if (in_level != in_prev)
        begin
            if (edge_cnt == factor_m1)
            begin
                next_edge_cnt  = '0;
                next_out_level = ~out_level;
            end
            else
            begin
                next_edge_cnt = edge_cnt + 1'b1;
            end
        end
    end

    // state registers
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            in_prev   <= 1'b0;
            edge_cnt  <= '0;
            out_level <= 1'b0;
        end
        else
        begin
            in_prev   <= next_in_prev;
            edge_cnt  <= next_edge_cnt;
            out_level <= next_out_level;
        end
    end
endmodule // scss_edge_div
`default_nettype wire

// *** test/scss_props.sv ***
// port assertions for the system clock source select block
`timescale 1ns/10ps
`default_nettype none
module scss_props #(
    parameter int INC_W = 16
) (
    input wire logic                       clk_sys,            // system clock
    input wire logic                       arst_n,             // async reset, active low
    input wire logic                       external_clock_pin, // direct drive level
    input wire logic                       crystal_input_pin,  // crystal level
    input wire logic                       internal_osc_clk,   // on-chip source level
    input wire logic                       wakeup_clk,         // wakeup level
    input wire scss_pkg::scss_sys_cfg_type sys_cfg,            // source config
    input wire scss_pkg::scss_pll_cfg_type pll_cfg,            // pll config
    input wire logic                       sys_clk,            // system clock level
    input wire scss_pkg::scss_src_type     active_source,      // source in use
    input wire logic                       pll_enable,         // pll running
    input wire logic                       pll_locked,         // pll locked
    input wire logic [INC_W-1:0]           vco_increment       // vco control word
);
    import scss_pkg::*;

    // oscillator seen by prescaler and pll, and mode decodes
    logic osc_level;
    logic pll_mode;
    logic pre_mode;
    assign osc_level = sys_cfg.osc_from_internal ? internal_osc_clk : crystal_input_pin;
    assign pll_mode  = sys_cfg.clock_source_select == 2'h2 && !sys_cfg.vco_bypass;
    assign pre_mode  = sys_cfg.clock_source_select == 2'h2 && sys_cfg.vco_bypass;

    // all checks on the logic clock
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    direct_drive_a: assert property (
        sys_cfg.clock_source_select == 2'h3 |=>
        sys_clk == $past(external_clock_pin) && active_source == SCSS_SRC_DIRECT)
        else $error("direct drive does not follow pin");
    wakeup_source_a: assert property (
        !sys_cfg.clock_source_select[1] |=>
        sys_clk == $past(wakeup_clk) && active_source == SCSS_SRC_WAKEUP)
        else $error("wakeup source not followed");
    prescale_source_a: assert property (
        pre_mode [*2] |-> active_source == SCSS_SRC_PRESCALER)
        else $error("prescaler not selected");
    pll_start_a: assert property (
        pll_mode [*3] |-> pll_enable && active_source == SCSS_SRC_PLL)
        else $error("pll not enabled");
    pll_stop_a: assert property (
        !pll_mode [*3] |-> !pll_enable && !pll_locked)
        else $error("pll left running");
    unit_pass_a: assert property (
        (pre_mode && sys_cfg.prescaler_divider_field == 10'h000) [*3] |->
        sys_clk == $past(osc_level, 2))
        else $error("factor one does not pass oscillator");
    smooth_step_a: assert property (
        pll_enable && $past(pll_enable) |->
        (vco_increment >= $past(vco_increment) ? vco_increment - $past(vco_increment)
            : $past(vco_increment) - vco_increment) <= 4)
        else $error("vco control word jumped");
    band_range_a: assert property (
        pll_locked |-> ($past(pll_cfg.vco_band_select) == 2'h0) ?
        (vco_increment >= 16'h0500 && vco_increment <= 16'h0B00) :
        (vco_increment >= 16'h0A00 && vco_increment <= 16'h1000))
        else $error("locked outside vco band");
endmodule // scss_props
`default_nettype wire

// *** test/scss_clk_src.sv ***
// behavioural clock sources at the block's far side
`timescale 1ns/10ps
`default_nettype none
module scss_clk_src (
    input  wire logic             clk_sys,   // system clock
    input  wire logic             arst_n,    // async reset, active low
    input  wire logic [3:0][11:0] half_cyc,  // half periods: ext, xtal, internal, wakeup
    output var  logic [3:0]       lvl        // source levels
);
    logic [3:0][11:0] cnt;

    // each source toggles after its half period, off the logic clock edge
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt <= '0;
            lvl <= '0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (cnt[i] + 12'h001 >= half_cyc[i])
                begin
                    cnt[i] <= '0;
                    lvl[i] <= ~lvl[i];
                end
                else
                begin
                    cnt[i] <= cnt[i] + 12'h001;
                end
            end
        end
    end
endmodule // scss_clk_src
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the system clock source select block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import scss_pkg::*;
    logic             clk_sys;       // system clock
    logic             arst_n;        // async reset, active low
    logic [3:0][11:0] half_cyc;      // source half periods
    logic [3:0]       lvl;           // source levels
    scss_sys_cfg_type sys_cfg;       // source config
    scss_pll_cfg_type pll_cfg;       // pll config
    logic             sys_clk;       // system clock level
    scss_src_type     active_source; // source in use
    logic             pll_enable;    // pll running
    logic             pll_locked;    // pll locked
    logic [15:0]      vco_increment; // vco control word
    int               failures;
    int               num_checks;

    scss_clk_src src_u (.clk_sys(clk_sys), .arst_n(arst_n), .half_cyc(half_cyc), .lvl(lvl));
    scss_top dut_u (
        .clk_sys            (clk_sys),
        .arst_n             (arst_n),
        .external_clock_pin (lvl[0]),
        .crystal_input_pin  (lvl[1]),
        .internal_osc_clk   (lvl[2]),
        .wakeup_clk         (lvl[3]),
        .sys_cfg            (sys_cfg),
        .pll_cfg            (pll_cfg),
        .sys_clk            (sys_clk),
        .active_source      (active_source),
        .pll_enable         (pll_enable),
        .pll_locked         (pll_locked),
        .vco_increment      (vco_increment)
    );

    // 100 MHz logic clock
    always #5 clk_sys = ~clk_sys;

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // one cycle forward, past the edge's updates; gives up past the bound
    task automatic step(inout int n, input int lim);
        @(posedge clk_sys);
        #1;
        n++;
        if (n > lim)
        begin
            check(1'b0, "wait bound used up");
            tally_and_finish();
        end
    endtask

    // config changes land on the rising edge
    task automatic set_cfg(input scss_sys_cfg_type s, input scss_pll_cfg_type p);
        @(posedge clk_sys);
        sys_cfg <= s;
        pll_cfg <= p;
    endtask

    // cycles until the system clock changes level
    task automatic wait_edge(input int lim, output int n);
        logic last;
        last = sys_clk;
        n = 0;
        while (sys_clk === last)
            step(n, lim);
    endtask

    task automatic count_rises(input int cyc, output int r);
        logic last;
        int n;
        r = 0;
        n = 0;
        last = sys_clk;
        repeat (cyc)
        begin
            step(n, cyc);
            if (sys_clk === 1'b1 && last === 1'b0)
                r++;
            last = sys_clk;
        end
    endtask

    // system clock tracks one source with one edge of delay
    task automatic follow(input logic [1:0] sel, input int idx, input scss_src_type src);
        logic prev;
        int n;
        n = 0;
        set_cfg('{sel, 1'b0, 1'b0, 10'h000}, pll_cfg);
        repeat (2) step(n, 4);
        repeat (12)
        begin
            prev = lvl[idx];
            step(n, 20);
            check(sys_clk === prev && active_source === src, "source not followed");
        end
    endtask

    task automatic t_direct;
        follow(2'h3, 0, SCSS_SRC_DIRECT);
        $display("test direct done");
    endtask

    task automatic t_wakeup;
        follow(2'h0, 3, SCSS_SRC_WAKEUP);
        follow(2'h1, 3, SCSS_SRC_WAKEUP);
        $display("test wakeup done");
    endtask

    // half period of output is factor times oscillator half period
    task automatic t_prescale;
        int n;
        for (int f = 0; f < 3; f++)
        begin
            set_cfg('{2'h2, 1'b1, 1'b0, 10'(f)}, pll_cfg);
            repeat (3) wait_edge(40, n);
            check(n == 3 * (f + 1), "prescale period");
        end
        // internal source passed through at factor one
        set_cfg('{2'h2, 1'b1, 1'b1, 10'h000}, pll_cfg);
        repeat (3) wait_edge(120, n);
        check(n == 96, "internal source prescale period");
        // largest factor on the crystal: 1024 crystal half periods
        set_cfg('{2'h2, 1'b1, 1'b0, 10'h3FF}, pll_cfg);
        repeat (3) wait_edge(3200, n);
        check(n == 3072, "largest prescale period");
        $display("test prescale done");
    endtask

    // pll from internal source, ref 192 cycles, N 2, K2 1 then 2
    task automatic t_pll;
        int n;
        n = 0;
        set_cfg('{2'h2, 1'b0, 1'b1, 10'h000}, '{4'h0, 7'h01, 7'h00, 2'h0});
        while (pll_locked !== 1'b1)
            step(n, 20000);
        check(pll_enable === 1'b1 && active_source === SCSS_SRC_PLL, "pll not running");
        count_rises(1536, n);
        check(n >= 14 && n <= 18, "pll ratio with K2 one");
        set_cfg(sys_cfg, '{4'h0, 7'h01, 7'h01, 2'h0});
        count_rises(400, n);
        count_rises(1536, n);
        check(n >= 6 && n <= 10, "pll ratio with K2 two");
        $display("test pll done");
    endtask

    // fields change while the pll is off; lock needs the high band
    task automatic t_band;
        int n;
        n = 0;
        set_cfg('{2'h0, 1'b0, 1'b1, 10'h000}, '{4'h0, 7'h01, 7'h00, 2'h1});
        repeat (4) step(n, 8);
        check(pll_enable === 1'b0 && pll_locked === 1'b0, "pll still on");
        set_cfg('{2'h2, 1'b0, 1'b1, 10'h000}, pll_cfg);
        half_cyc[2] <= 12'h028;
        n = 0;
        while (pll_locked !== 1'b1)
            step(n, 45000);
        check(vco_increment > 16'h0B00 && vco_increment <= 16'h1000, "vco band");
        $display("test band done");
    endtask

    initial
    begin
        clk_sys = 1'b0;
        arst_n = 1'b0;
        half_cyc = {12'h005, 12'h060, 12'h003, 12'h002};
        sys_cfg = '0;
        pll_cfg = '0;
        failures = 0;
        num_checks = 0;
        repeat (3) @(posedge clk_sys);
        #1;
        check(sys_clk === 1'b0 && vco_increment === 16'h0500 && pll_enable === 1'b0,
              "reset values");
        @(posedge clk_sys);
        arst_n <= 1'b1;
        t_direct();
        t_wakeup();
        t_prescale();
        t_pll();
        t_band();
        tally_and_finish();
    end
endmodule // tb_top

bind scss_top scss_props #(.INC_W(INC_W)) props_u (
    .clk_sys, .arst_n, .external_clock_pin, .crystal_input_pin, .internal_osc_clk,
    .wakeup_clk, .sys_cfg, .pll_cfg, .sys_clk, .active_source, .pll_enable,
    .pll_locked, .vco_increment
);
`default_nettype wire
